// File: core/tpc_pkg.sv
package tpc_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int NUM_CH = 2;
  localparam int PS_W = 7;

  // ****************************************
  // Values after reset and fixed counts
  // ****************************************
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] MOD_RST = 16'h0000;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [6:0] PS_RST = 7'h00;
  localparam logic [6:0] PS_ONE = 7'h01;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ****************************************
  // Field encodings
  // ****************************************
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_RISE_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_FALL_CLEAR = 2'h2;
  localparam logic [1:0] ELS_BOTH_SET = 2'h3;
  localparam logic [1:0] MS_CAPTURE = 2'h0;
  localparam logic [1:0] MS_COMPARE = 2'h1;

  typedef enum logic [1:0] {
    CLKS_OFF = 2'h0,
    CLKS_BUS = 2'h1,
    CLKS_FIXED = 2'h2,
    CLKS_EXT = 2'h3
  } tpc_clksel_t;

  typedef enum logic [2:0] {
    TGT_MOD_HI = 3'h0,
    TGT_MOD_LO = 3'h1,
    TGT_CNT_HI = 3'h2,
    TGT_CNT_LO = 3'h3,
    TGT_CH0_HI = 3'h4,
    TGT_CH0_LO = 3'h5,
    TGT_CH1_HI = 3'h6,
    TGT_CH1_LO = 3'h7
  } tpc_target_t;

  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } tpc_dir_t;

endpackage

// File: core/tpc_tick_if.sv
`timescale 1ns/1ps
`default_nettype none

interface tpc_tick_if;
  logic [1:0] clkSel;
  logic [2:0] prescale;
  logic hold;
  logic countClear;
  logic tick;

  modport gen (
    input clkSel,
    input prescale,
    input hold,
    input countClear,
    output tick
  );

  modport use_side (
    output clkSel,
    output prescale,
    output hold,
    output countClear,
    input tick
  );
endinterface

`default_nettype wire

// File: core/tpc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module tpc_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] stage1Reg;
  logic [W-1:0] stage2Reg;

  // Stage one feeds stage two only
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stage1Reg <= '0;
      stage2Reg <= '0;
    end else begin
      stage1Reg <= asyncIn;
      stage2Reg <= stage1Reg;
    end
  end

  assign syncOut = stage2Reg;

endmodule

`default_nettype wire

// File: core/tpc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module tpc_prescaler (
  input wire logic core_clk,
  input wire logic rstn,
  tpc_tick_if.gen tickIf,
  input wire logic fixedClkSync,
  input wire logic extClkSync
);

  logic fixedPrevReg;
  logic extPrevReg;
  logic [6:0] divReg;
  logic tickReg;
  logic srcEdge;
  logic [6:0] divMask;

  // ****************************************
  // Source edge select
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fixedPrevReg <= 1'b0;
      extPrevReg <= 1'b0;
    end else begin
      fixedPrevReg <= fixedClkSync;
      extPrevReg <= extClkSync;
    end
  end

  always_comb begin
    case (tickIf.clkSel)
      tpc_pkg::CLKS_BUS: srcEdge = 1'b1;
      tpc_pkg::CLKS_FIXED: srcEdge = fixedClkSync & ~fixedPrevReg;
      tpc_pkg::CLKS_EXT: srcEdge = extClkSync & ~extPrevReg;
      default: srcEdge = 1'b0;
    endcase
  end

  // ****************************************
  // Divider taps
  // ****************************************
  assign divMask = (tpc_pkg::PS_ONE << tickIf.prescale) - tpc_pkg::PS_ONE;

  // Divider freezes with the counter in debug hold so no half-period is lost; clock off clears it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      divReg <= tpc_pkg::PS_RST;
    end else if (tickIf.countClear || tickIf.clkSel == tpc_pkg::CLKS_OFF) begin
      divReg <= tpc_pkg::PS_RST;
    end else if (srcEdge && !tickIf.hold) begin
      divReg <= divReg + tpc_pkg::PS_ONE;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tickReg <= 1'b0;
    end else begin
      tickReg <= srcEdge && !tickIf.hold && !tickIf.countClear && ((divReg & divMask) == divMask);
    end
  end

  assign tickIf.tick = tickReg;

endmodule

`default_nettype wire

// File: core/tpc_top.sv
`timescale 1ns/1ps
`default_nettype none

module tpc_top #(
  parameter int NUM_CH = tpc_pkg::NUM_CH
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic bdmActive,
  input wire logic centerAligned,
  input wire logic [1:0] clockSelect,
  input wire logic [2:0] prescaleSelect,
  input wire logic [NUM_CH-1:0][1:0] chanModeSelect,
  input wire logic [NUM_CH-1:0][1:0] edgeLevelSelect,
  input wire logic [NUM_CH-1:0] chanPinPositionSelect,
  input wire logic [NUM_CH-1:0] chanIrqEnable,
  input wire logic overflowIrqEnable,
  input wire logic [NUM_CH-1:0] chanFlagClear,
  input wire logic overflowFlagClear,
  input wire logic byteWriteEn,
  input wire logic [2:0] byteWriteTarget,
  input wire logic [7:0] byteWriteData,
  input wire logic [2:0] byteReadTarget,
  output logic [7:0] byteReadData,
  input wire logic fixedClockIn,
  input wire logic extCountClockIn,
  input wire logic [NUM_CH-1:0] chanPinPrimaryIn,
  input wire logic [NUM_CH-1:0] chanPinAltIn,
  output logic [NUM_CH-1:0] chanPinPrimaryOut,
  output logic [NUM_CH-1:0] chanPinPrimaryOe,
  output logic [NUM_CH-1:0] chanPinAltOut,
  output logic [NUM_CH-1:0] chanPinAltOe,
  output logic [NUM_CH-1:0] chanFlag,
  output logic overflowFlag,
  output logic [NUM_CH-1:0] chanIrq,
  output logic overflowIrq
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [2:0] chanTarget(input int ch, input logic lowByte);
    chanTarget = 3'(int'(tpc_pkg::TGT_CH0_HI) + 2 * ch + int'(lowByte));
  endfunction

  function automatic logic captureHit(input logic [1:0] els, input logic rise, input logic fall);
    case (els)
      tpc_pkg::ELS_RISE_TOGGLE: captureHit = rise;
      tpc_pkg::ELS_FALL_CLEAR: captureHit = fall;
      tpc_pkg::ELS_BOTH_SET: captureHit = rise | fall;
      default: captureHit = 1'b0;
    endcase
  endfunction

  // ****************************************
  // Pin synchronisers and prescaler
  // ****************************************
  localparam int SYNC_W = 2 * NUM_CH + 2;

  logic [SYNC_W-1:0] syncIn;
  logic [SYNC_W-1:0] syncOut;
  logic [NUM_CH-1:0] primSync;
  logic [NUM_CH-1:0] altSync;
  logic cntWrite;

  assign syncIn = {extCountClockIn, fixedClockIn, chanPinAltIn, chanPinPrimaryIn};
  assign primSync = syncOut[NUM_CH-1:0];
  assign altSync = syncOut[2*NUM_CH-1:NUM_CH];

  tpc_sync #(.W(SYNC_W)) pinSync (
    .core_clk(core_clk),
    .rstn(rstn),
    .asyncIn(syncIn),
    .syncOut(syncOut)
  );

  tpc_tick_if tickIf ();

  assign tickIf.clkSel = clockSelect;
  assign tickIf.prescale = prescaleSelect;
  assign tickIf.hold = bdmActive;
  assign tickIf.countClear = cntWrite;

  tpc_prescaler prescaler (
    .core_clk(core_clk),
    .rstn(rstn),
    .tickIf(tickIf),
    .fixedClkSync(syncOut[2*NUM_CH]),
    .extClkSync(syncOut[2*NUM_CH+1])
  );

  // ****************************************
  // Counter
  // ****************************************
  logic [15:0] countReg;
  logic [15:0] countNext;
  logic [15:0] moduloReg;
  logic [15:0] topVal;
  tpc_pkg::tpc_dir_t dirReg;
  tpc_pkg::tpc_dir_t dirNext;
  logic stepUp;
  logic wrapEvt;
  logic cntStep;
  logic clkOn;
  logic overflowFlagReg;

  assign clkOn = clockSelect != tpc_pkg::CLKS_OFF;
  assign cntWrite = byteWriteEn && (byteWriteTarget == tpc_pkg::TGT_CNT_HI
                    || byteWriteTarget == tpc_pkg::TGT_CNT_LO);
  // Stop mode needs nothing here: with core_clk stopped all state freezes
  assign cntStep = tickIf.tick && !bdmActive && clkOn && !cntWrite;
  assign topVal = (moduloReg == tpc_pkg::MOD_RST || moduloReg == tpc_pkg::CNT_ALL_ONES)
                  ? tpc_pkg::CNT_ALL_ONES : moduloReg;

  always_comb begin
    countNext = countReg;
    dirNext = dirReg;
    stepUp = 1'b1;
    wrapEvt = 1'b0;
    if (cntWrite) begin
      countNext = tpc_pkg::CNT_RST;
      dirNext = tpc_pkg::DIR_UP;
    end else if (cntStep) begin
      if (centerAligned) begin
        case (dirReg)
          tpc_pkg::DIR_UP: begin
            if (countReg >= topVal) begin
              dirNext = tpc_pkg::DIR_DOWN;
              countNext = countReg - tpc_pkg::CNT_ONE;
              stepUp = 1'b0;
            end else begin
              countNext = countReg + tpc_pkg::CNT_ONE;
            end
          end
          tpc_pkg::DIR_DOWN: begin
            if (countReg == tpc_pkg::CNT_RST) begin
              dirNext = tpc_pkg::DIR_UP;
              countNext = countReg + tpc_pkg::CNT_ONE;
              wrapEvt = 1'b1;
            end else begin
              countNext = countReg - tpc_pkg::CNT_ONE;
              stepUp = 1'b0;
            end
          end
          default: begin
            dirNext = tpc_pkg::DIR_UP;
          end
        endcase
      end else begin
        dirNext = tpc_pkg::DIR_UP;
        if (countReg == topVal) begin
          countNext = tpc_pkg::CNT_RST;
          wrapEvt = 1'b1;
        end else begin
          countNext = countReg + tpc_pkg::CNT_ONE;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      countReg <= tpc_pkg::CNT_RST;
      dirReg <= tpc_pkg::DIR_UP;
    end else begin
      countReg <= countNext;
      dirReg <= dirNext;
    end
  end

  // Modulo takes each byte as written; no buffering of the pair
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      moduloReg <= tpc_pkg::MOD_RST;
    end else if (byteWriteEn && byteWriteTarget == tpc_pkg::TGT_MOD_HI) begin
      moduloReg[15:8] <= byteWriteData;
    end else if (byteWriteEn && byteWriteTarget == tpc_pkg::TGT_MOD_LO) begin
      moduloReg[7:0] <= byteWriteData;
    end
  end

  // Set wins over clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      overflowFlagReg <= 1'b0;
    end else begin
      overflowFlagReg <= wrapEvt | (overflowFlagReg & ~overflowFlagClear);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      overflowIrq <= 1'b0;
    end else begin
      overflowIrq <= overflowFlagReg & overflowIrqEnable;
    end
  end

  assign overflowFlag = overflowFlagReg;

  // ****************************************
  // Channels
  // ****************************************
  logic [NUM_CH-1:0][15:0] chanValReg;
  logic [NUM_CH-1:0] chanFlagReg;
  logic [NUM_CH-1:0] chanLvlReg;
  logic [NUM_CH-1:0] pinPrevReg;
  logic [NUM_CH-1:0] capEvt;
  logic [NUM_CH-1:0] matchEvt;
  logic [NUM_CH-1:0] pinDrive;

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : gChan
    logic [1:0] els;
    logic [1:0] ms;
    logic elsOn;
    logic pinIn;
    logic capMode;
    logic cmpMode;
    logic epwmMode;
    logic cpwmMode;
    logic flagEvt;

    assign els = edgeLevelSelect[ch];
    assign ms = chanModeSelect[ch];
    assign elsOn = els != tpc_pkg::ELS_OFF;
    assign pinIn = chanPinPositionSelect[ch] ? altSync[ch] : primSync[ch];
    assign cpwmMode = centerAligned;
    assign capMode = !centerAligned && ms == tpc_pkg::MS_CAPTURE && elsOn && clkOn;
    assign cmpMode = !centerAligned && ms == tpc_pkg::MS_COMPARE;
    assign epwmMode = !centerAligned && ms[1];
    assign pinDrive[ch] = clkOn && elsOn && (cpwmMode || epwmMode || cmpMode);
    assign capEvt[ch] = capMode && captureHit(els, pinIn & ~pinPrevReg[ch], ~pinIn & pinPrevReg[ch]);
    assign matchEvt[ch] = cntStep && countNext == chanValReg[ch];
    // Compare flags even with the pin left alone, for software timing
    assign flagEvt = capEvt[ch] || (matchEvt[ch] && !capMode);

    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        pinPrevReg[ch] <= 1'b0;
      end else begin
        pinPrevReg[ch] <= pinIn;
      end
    end

    // A capture outranks a software byte write in the same cycle
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        chanValReg[ch] <= tpc_pkg::VAL_RST;
      end else if (capEvt[ch]) begin
        chanValReg[ch] <= countReg;
      end else if (byteWriteEn && byteWriteTarget == chanTarget(ch, 1'b0)) begin
        chanValReg[ch][15:8] <= byteWriteData;
      end else if (byteWriteEn && byteWriteTarget == chanTarget(ch, 1'b1)) begin
        chanValReg[ch][7:0] <= byteWriteData;
      end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        chanFlagReg[ch] <= 1'b0;
      end else begin
        chanFlagReg[ch] <= flagEvt | (chanFlagReg[ch] & ~chanFlagClear[ch]);
      end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        chanIrq[ch] <= 1'b0;
      end else begin
        chanIrq[ch] <= chanFlagReg[ch] & chanIrqEnable[ch];
      end
    end

    // Level holds when the pin is released so toggle resumes from it
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        chanLvlReg[ch] <= 1'b0;
      end else if (clkOn && elsOn) begin
        if (cpwmMode) begin
          if (matchEvt[ch]) begin
            chanLvlReg[ch] <= stepUp ? els[0] : ~els[0];
          end
        end else if (epwmMode) begin
          if (matchEvt[ch]) begin
            chanLvlReg[ch] <= els[0];
          end else if (cntStep && countNext == tpc_pkg::CNT_RST) begin
            chanLvlReg[ch] <= ~els[0];
          end
        end else if (cmpMode && matchEvt[ch]) begin
          case (els)
            tpc_pkg::ELS_RISE_TOGGLE: chanLvlReg[ch] <= ~chanLvlReg[ch];
            tpc_pkg::ELS_FALL_CLEAR: chanLvlReg[ch] <= 1'b0;
            tpc_pkg::ELS_BOTH_SET: chanLvlReg[ch] <= 1'b1;
            default: chanLvlReg[ch] <= chanLvlReg[ch];
          endcase
        end
      end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        chanPinPrimaryOe[ch] <= 1'b0;
        chanPinAltOe[ch] <= 1'b0;
      end else begin
        chanPinPrimaryOe[ch] <= pinDrive[ch] && !chanPinPositionSelect[ch];
        chanPinAltOe[ch] <= pinDrive[ch] && chanPinPositionSelect[ch];
      end
    end

    assign chanPinPrimaryOut[ch] = chanLvlReg[ch];
    assign chanPinAltOut[ch] = chanLvlReg[ch];

    capture_copy_a: assert property (@(posedge core_clk) disable iff (!rstn)
      capEvt[ch] |=> chanValReg[ch] == $past(countReg) && chanFlagReg[ch])
      else $error("capture did not copy counter and set flag");

    compare_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
      clkOn && cmpMode && els == tpc_pkg::ELS_BOTH_SET && matchEvt[ch] |=> chanLvlReg[ch] && chanFlagReg[ch])
      else $error("compare set action missing");

    release_pin_a: assert property (@(posedge core_clk) disable iff (!rstn)
      !clkOn || !elsOn |=> !chanPinPrimaryOe[ch] && !chanPinAltOe[ch])
      else $error("pin still driven when released");

    flag_set_wins_a: assert property (@(posedge core_clk) disable iff (!rstn)
      flagEvt && chanFlagClear[ch] |=> chanFlagReg[ch] ##1 (chanIrq[ch] == chanIrqEnable[ch]) || chanFlagClear[ch])
      else $error("flag lost on clear collision");
  end

  assign chanFlag = chanFlagReg;

  // ****************************************
  // Byte read port
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      byteReadData <= tpc_pkg::BYTE_RST;
    end else begin
      case (byteReadTarget)
        tpc_pkg::TGT_MOD_HI: byteReadData <= moduloReg[15:8];
        tpc_pkg::TGT_MOD_LO: byteReadData <= moduloReg[7:0];
        tpc_pkg::TGT_CNT_HI: byteReadData <= countReg[15:8];
        tpc_pkg::TGT_CNT_LO: byteReadData <= countReg[7:0];
        tpc_pkg::TGT_CH0_HI: byteReadData <= chanValReg[0][15:8];
        tpc_pkg::TGT_CH0_LO: byteReadData <= chanValReg[0][7:0];
        tpc_pkg::TGT_CH1_HI: byteReadData <= chanValReg[NUM_CH-1][15:8];
        default: byteReadData <= chanValReg[NUM_CH-1][7:0];
      endcase
    end
  end

  // ****************************************
  // Counter checks
  // ****************************************
  sequence edgeWrapSeq;
    !centerAligned && cntStep && countReg == topVal;
  endsequence

  sequence centerTurnSeq;
    centerAligned && cntStep && dirReg == tpc_pkg::DIR_UP && countReg >= topVal;
  endsequence

  count_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
    cntWrite |=> countReg == 16'h0000 && dirReg == tpc_pkg::DIR_UP)
    else $error("counter byte write did not clear counter");

  debug_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    bdmActive && !cntWrite |=> $stable(countReg))
    else $error("counter moved during debug");

  edge_wrap_a: assert property (@(posedge core_clk) disable iff (!rstn)
    edgeWrapSeq |=> countReg == 16'h0000 && overflowFlagReg)
    else $error("edge mode period end wrong");

  free_run_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !centerAligned && cntStep && (moduloReg == 16'h0000 || moduloReg == 16'hFFFF) && countReg != 16'hFFFF
    |=> countReg == $past(countReg) + 16'h0001)
    else $error("free run count did not advance");

  center_turn_a: assert property (@(posedge core_clk) disable iff (!rstn)
    centerTurnSeq |=> dirReg == tpc_pkg::DIR_DOWN && countReg == $past(countReg) - 16'h0001)
    else $error("center mode did not turn at modulo");

  center_bottom_a: assert property (@(posedge core_clk) disable iff (!rstn)
    centerAligned && cntStep && dirReg == tpc_pkg::DIR_DOWN && countReg == 16'h0000
    |=> dirReg == tpc_pkg::DIR_UP && overflowFlagReg ##1 overflowIrq == overflowIrqEnable || overflowFlagClear)
    else $error("center mode did not turn at zero");

  clock_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
    clockSelect == tpc_pkg::CLKS_OFF && !cntWrite |=> $stable(countReg))
    else $error("counter ran with clock off");

endmodule

`default_nettype wire

// File: sim/tpc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Far side of the channel pins
// ****************************************
module tpc_pin_model (
  input wire logic [1:0] pOut,
  input wire logic [1:0] pOe,
  input wire logic [1:0] aOut,
  input wire logic [1:0] aOe,
  input wire logic [1:0] drv,
  output logic [1:0] pIn,
  output logic [1:0] aIn
);
  // Released pins show the far side's level, never stale timer data
  assign pIn = (pOe & pOut) | (~pOe & drv);
  assign aIn = (aOe & aOut) | (~aOe & drv);
endmodule

`default_nettype wire

// File: sim/tpc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin errCount++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end

// ****************************************
// Bench
// ****************************************
module tpc_top_tb_top;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic background_debug_mode = 1'b0, cen = 1'b0, ovEn = 1'b0, ovClr = 1'b0, wEn = 1'b0;
  logic [1:0] cks = 2'h0;
  logic [2:0] ps = 3'h0;
  logic ext = 1'b0;
  logic [2:0] wT = 3'h0, rT = 3'h0;
  logic [7:0] wD = 8'h00, rD;
  logic [1:0][1:0] ms = '0, els = '0;
  logic [1:0] pos = 2'h0, irqEn = 2'h3, fClr = 2'h0, drv = 2'h0;
  logic [1:0] pIn, aIn, pOut, pOe, aOut, aOe, flag, irq;
  logic ovFlag, ovIrq;
  int errCount = 0;
  int nCompared = 0;
  int h0, h1, bad;

  tpc_top tpc_top_i (.core_clk(core_clk), .rstn(rstn), .bdmActive(background_debug_mode), .centerAligned(cen),
    .clockSelect(cks), .prescaleSelect(ps), .chanModeSelect(ms), .edgeLevelSelect(els),
    .chanPinPositionSelect(pos), .chanIrqEnable(irqEn), .overflowIrqEnable(ovEn),
    .chanFlagClear(fClr), .overflowFlagClear(ovClr), .byteWriteEn(wEn), .byteWriteTarget(wT),
    .byteWriteData(wD), .byteReadTarget(rT), .byteReadData(rD), .fixedClockIn(ext),
    .extCountClockIn(ext), .chanPinPrimaryIn(pIn), .chanPinAltIn(aIn), .chanPinPrimaryOut(pOut),
    .chanPinPrimaryOe(pOe), .chanPinAltOut(aOut), .chanPinAltOe(aOe), .chanFlag(flag),
    .overflowFlag(ovFlag), .chanIrq(irq), .overflowIrq(ovIrq));

  tpc_pin_model tpc_pin_model_i (.pOut(pOut), .pOe(pOe), .aOut(aOut), .aOe(aOe), .drv(drv),
    .pIn(pIn), .aIn(aIn));

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] t, input logic [7:0] d);
    @(negedge core_clk);
    wEn = 1'b1;
    wT = t;
    wD = d;
    @(negedge core_clk);
    wEn = 1'b0;
  endtask

  task automatic rd(input logic [2:0] t, output logic [7:0] v);
    rT = t;
    repeat (2) @(negedge core_clk);
    v = rD;
  endtask

  // Index 2 is the overflow flag; clears it first, then waits for a fresh set
  task automatic waitBit(input int idx);
    @(negedge core_clk);
    if (idx == 2) ovClr = 1'b1;
    else fClr[idx] = 1'b1;
    @(negedge core_clk);
    ovClr = 1'b0;
    fClr = 2'h0;
    for (int i = 0; i < 300; i++) begin
      @(negedge core_clk);
      if ((idx == 2 ? ovFlag : flag[idx]) === 1'b1) return;
    end
    errCount++;
    $display("mismatch t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    test_done();
  endtask

  // Channel 0 read on the alternate pin, channel 1 on the primary pin
  task automatic hiCount(input int n);
    h0 = 0;
    h1 = 0;
    bad = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      h0 += int'(aOut[0] === 1'b1);
      h1 += int'(pOut[1] === 1'b1);
      bad += int'(pOut[1] === 1'b1 && aOut[0] !== 1'b1);
    end
  endtask

  task automatic t_reset();
    `CHK({pOe, aOe, flag, ovFlag, irq, ovIrq}, 10'h000)
    $display("test reset done");
  endtask

  task automatic t_capture();
    logic [7:0] v;
    background_debug_mode = 1'b1;
    cks = 2'h1;
    wr(tpc_pkg::TGT_CH0_LO, 8'hAA);
    wr(tpc_pkg::TGT_CNT_LO, 8'h5A);
    ms[0] = tpc_pkg::MS_CAPTURE;
    els[0] = tpc_pkg::ELS_RISE_TOGGLE;
    repeat (4) @(negedge core_clk);
    drv[0] = 1'b1;
    waitBit(0);
    rd(tpc_pkg::TGT_CH0_LO, v);
    `CHK(v, 8'h00)
    rd(tpc_pkg::TGT_CNT_LO, v);
    `CHK(v, 8'h00)
    els[0] = tpc_pkg::ELS_FALL_CLEAR;
    drv[0] = 1'b0;
    waitBit(0);
    `CHK(pOe[0], 1'b0)
    els[0] = tpc_pkg::ELS_OFF;
    fClr[0] = 1'b1;
    @(negedge core_clk);
    fClr[0] = 1'b0;
    drv[0] = 1'b1;
    repeat (8) @(negedge core_clk);
    `CHK(flag[0], 1'b0)
    background_debug_mode = 1'b0;
    $display("test capture done");
  endtask

  task automatic t_compare();
    logic [1:0] act [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
    logic expv [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    ms[0] = tpc_pkg::MS_COMPARE;
    wr(tpc_pkg::TGT_MOD_LO, 8'h07);
    wr(tpc_pkg::TGT_CH0_LO, 8'h03);
    for (int k = 0; k < 4; k++) begin
      els[0] = act[k];
      waitBit(0);
      `CHK({pOe[0], pOut[0]}, {1'b1, expv[k]})
    end
    $display("test compare done");
  endtask

  task automatic t_edge();
    ms = {2'h2, 2'h2};
    els = {2'h2, 2'h2};
    pos = 2'h1;
    ovEn = 1'b1;
    wr(tpc_pkg::TGT_MOD_LO, 8'h04);
    wr(tpc_pkg::TGT_CH0_LO, 8'h02);
    wr(tpc_pkg::TGT_CH1_LO, 8'h01);
    // Counter may already be past the new modulo; restart it
    wr(tpc_pkg::TGT_CNT_LO, 8'h00);
    waitBit(2);
    @(negedge core_clk);
    `CHK({aOe, pOe, ovIrq, irq}, 7'h37)
    hiCount(10);
    `CHK({h0, h1, bad}, {32'd4, 32'd2, 32'd0})
    els[0] = 2'h3;
    waitBit(2);
    hiCount(10);
    `CHK(h0, 6)
    cks = 2'h0;
    repeat (3) @(negedge core_clk);
    `CHK(aOe[0], 1'b0)
    cks = 2'h1;
    $display("test edge pwm done");
  endtask

  task automatic t_clock();
    logic [7:0] v;
    wr(tpc_pkg::TGT_MOD_LO, 8'h00);
    ps = 3'h3;
    wr(tpc_pkg::TGT_CNT_LO, 8'h00);
    // Read mid-step so pipeline slack of a cycle or two does not matter
    repeat (84) @(negedge core_clk);
    rd(tpc_pkg::TGT_CNT_LO, v);
    `CHK(v, 8'h0A)
    ps = 3'h0;
    for (int m = 2; m < 4; m++) begin
      cks = 2'(m);
      wr(tpc_pkg::TGT_CNT_LO, 8'h00);
      repeat (5) begin
        ext = 1'b1;
        repeat (4) @(negedge core_clk);
        ext = 1'b0;
        repeat (4) @(negedge core_clk);
      end
      repeat (8) @(negedge core_clk);
      rd(tpc_pkg::TGT_CNT_LO, v);
      `CHK(v, 8'h05)
    end
    cks = 2'h1;
    wr(tpc_pkg::TGT_MOD_LO, 8'h04);
    wr(tpc_pkg::TGT_CNT_LO, 8'h00);
    $display("test clock select done");
  endtask

  task automatic t_center();
    cen = 1'b1;
    ms[0] = tpc_pkg::MS_COMPARE;
    els = {2'h2, 2'h2};
    waitBit(2);
    hiCount(16);
    `CHK({h0, h1, bad}, {32'd8, 32'd4, 32'd0})
    $display("test center pwm done");
  endtask

  initial begin
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    repeat (2) @(negedge core_clk);
    t_reset();
    t_capture();
    t_compare();
    t_edge();
    t_clock();
    t_center();
    test_done();
  end
endmodule

`default_nettype wire
